// ==== design/dsp_accumulator_access_unit.sv ====
// accumulator and control-register access datapath, one op per cycle
`timescale 1ns/1ps
module dsp_accumulator_access_unit (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic issue_i,
  input wire daau_pkg::daau_op_t op_i,
  input wire logic [daau_pkg::SEL_W-1:0] acc_select_i,
  input wire logic [daau_pkg::WORD_W-1:0] source_reg_i,
  input wire logic [daau_pkg::WORD_W-1:0] target_reg_i,
  input wire logic [daau_pkg::SH6_W-1:0] imm_i,
  input wire logic [daau_pkg::MASK_W-1:0] mask_i,
  output logic done_o,
  output logic gpr_wr_o,
  output logic [daau_pkg::WORD_W-1:0] gpr_data_o,
  output logic acc_wr_o,
  output logic [daau_pkg::SEL_W-1:0] acc_sel_o,
  output logic [daau_pkg::WORD_W-1:0] acc_high_half_o,
  output logic [daau_pkg::WORD_W-1:0] acc_low_half_o,
  output logic branch_valid_o,
  output logic branch_taken_o,
  output logic [daau_pkg::WORD_W-1:0] signal_proc_ctrl_reg_o
);
  import daau_pkg::*;

  // all state of the unit
  typedef struct packed {
    logic [ACC_N-1:0][ACC_W-1:0] acc;
    logic [WORD_W-1:0] ctrl;
    logic done;
    logic gpr_wr;
    logic [WORD_W-1:0] gpr_data;
    logic acc_wr;
    logic [SEL_W-1:0] acc_sel;
    logic [WORD_W-1:0] acc_hi;
    logic [WORD_W-1:0] acc_lo;
    logic br_valid;
    logic br_taken;
  } daau_state_t;

  daau_state_t st_r;
  daau_state_t st_nxt;

  daau_xt_if xt ();

  // expands a mask argument into the control bits it covers
  function automatic logic [WORD_W-1:0] field_bits(input logic [MASK_W-1:0] m);
    logic [WORD_W-1:0] f;
    f = '0;
    if (m[0]) begin
      f = f | FLD_POS;
    end
    if (m[1]) begin
      f = f | FLD_CNT;
    end
    if (m[2]) begin
      f = f | FLD_LOW;
    end
    if (m[3]) begin
      f = f | FLD_B15;
    end
    if (m[4]) begin
      f = f | FLD_TOP;
    end
    return f;
  endfunction

  // extracts the position field
  function automatic logic [SH5_W-1:0] pos_of(input logic [WORD_W-1:0] c);
    return c[POS_MSB:POS_LSB];
  endfunction

  // writes a new position into a control word
  function automatic logic [WORD_W-1:0] with_pos(input logic [WORD_W-1:0] c,
                                                 input logic [6:0] p);
    logic [WORD_W-1:0] r;
    r = c;
    r[POS_MSB:POS_LSB] = p[SH5_W-1:0];
    return r;
  endfunction

  logic [ACC_W-1:0] cur_acc;
  logic [WORD_W-1:0] cur_hi;
  logic [WORD_W-1:0] cur_lo;
  logic [SH5_W-1:0] size_sel;
  logic [SH6_W-1:0] shift_amt;
  logic [ACC_W-1:0] shift_res;
  logic [WORD_W-1:0] fmask;
  logic [6:0] pos_wide;

  // selected accumulator and its halves
  assign cur_acc = st_r.acc[acc_select_i];
  assign cur_hi = cur_acc[ACC_W-1:WORD_W];
  assign cur_lo = cur_acc[WORD_W-1:0];
  assign pos_wide = {2'b00, pos_of(st_r.ctrl)};

  // field size from immediate or from source register
  always_comb begin
    case (op_i)
      OP_BF_VAR, OP_BF_VAR_DEC: begin
        size_sel = source_reg_i[SH5_W-1:0];
      end
      default: begin
        size_sel = imm_i[SH5_W-1:0];
      end
    endcase
  end

  // operand routing into the extract unit
  always_comb begin
    xt.acc = cur_acc;
    xt.pos = pos_of(st_r.ctrl);
    xt.round = 1'b0;
    xt.sat = 1'b0;
    xt.amount = source_reg_i[SH5_W-1:0];
    case (op_i)
      OP_HALF_SAT: begin
        xt.kind = XT_HALF;
      end
      OP_WORD: begin
        xt.kind = XT_WORD;
      end
      OP_WORD_R: begin
        xt.kind = XT_WORD;
        xt.round = 1'b1;
      end
      OP_WORD_RS: begin
        xt.kind = XT_WORD;
        xt.round = 1'b1;
        xt.sat = 1'b1;
      end
      OP_BF_IMM, OP_BF_VAR, OP_BF_IMM_DEC, OP_BF_VAR_DEC: begin
        xt.kind = XT_FIELD;
        xt.amount = size_sel;
      end
      default: begin
        xt.kind = XT_WORD;
      end
    endcase
  end

  daau_extract u_extract (
    .xt(xt)
  );

  // signed accumulator shift amount
  always_comb begin
    if (op_i == OP_SHIFT_VAR) begin
      shift_amt = source_reg_i[SH6_W-1:0];
    end else begin
      shift_amt = imm_i;
    end
  end

  // negative is a right shift up to 32, positive a left shift up to 31
  always_comb begin
    if (shift_amt[SH6_W-1]) begin
      shift_res = cur_acc >> (6'h00 - shift_amt);
    end else begin
      shift_res = cur_acc << shift_amt;
    end
  end

  assign fmask = field_bits(mask_i);

  // next state: one operation per issue, results held one cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.gpr_wr = 1'b0;
    st_nxt.acc_wr = 1'b0;
    st_nxt.br_valid = 1'b0;
    if (issue_i) begin
      st_nxt.done = 1'b1;
      st_nxt.acc_sel = acc_select_i;
      st_nxt.acc_hi = cur_hi;
      st_nxt.acc_lo = cur_lo;
      case (op_i)
        OP_HALF_SAT, OP_WORD, OP_WORD_R, OP_WORD_RS: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = xt.result;
        end
        OP_BF_IMM, OP_BF_VAR: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = xt.result;
        end
        OP_BF_IMM_DEC, OP_BF_VAR_DEC: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = xt.result;
          st_nxt.ctrl = with_pos(st_r.ctrl,
                                 pos_wide - {2'b00, size_sel} - 7'h01);
        end
        OP_SHIFT_IMM, OP_SHIFT_VAR: begin
          st_nxt.acc[acc_select_i] = shift_res;
          st_nxt.acc_wr = 1'b1;
          st_nxt.acc_hi = shift_res[ACC_W-1:WORD_W];
          st_nxt.acc_lo = shift_res[WORD_W-1:0];
        end
        OP_MOVE_INCPOS: begin
          st_nxt.acc[acc_select_i] = {cur_lo, source_reg_i};
          st_nxt.acc_wr = 1'b1;
          st_nxt.acc_hi = cur_lo;
          st_nxt.acc_lo = source_reg_i;
          st_nxt.ctrl = with_pos(st_r.ctrl, pos_wide + POS_STEP);
        end
        OP_MF_HI: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = cur_hi;
        end
        OP_MF_LO: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = cur_lo;
        end
        OP_MT_HI: begin
          st_nxt.acc[acc_select_i] = {source_reg_i, cur_lo};
          st_nxt.acc_wr = 1'b1;
          st_nxt.acc_hi = source_reg_i;
        end
        OP_MT_LO: begin
          st_nxt.acc[acc_select_i] = {cur_hi, source_reg_i};
          st_nxt.acc_wr = 1'b1;
          st_nxt.acc_lo = source_reg_i;
        end
        OP_CTRL_WR: begin
          st_nxt.ctrl = (st_r.ctrl & ~fmask) | (source_reg_i & fmask);
        end
        OP_CTRL_RD: begin
          st_nxt.gpr_wr = 1'b1;
          st_nxt.gpr_data = (target_reg_i & ~fmask) | (st_r.ctrl & fmask);
        end
        OP_BRANCH_POS: begin
          st_nxt.br_valid = 1'b1;
          st_nxt.br_taken = (pos_wide >= BRANCH_MIN);
        end
        default: begin
          st_nxt.done = 1'b1;
        end
      endcase
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state register
  assign done_o = st_r.done;
  assign gpr_wr_o = st_r.gpr_wr;
  assign gpr_data_o = st_r.gpr_data;
  assign acc_wr_o = st_r.acc_wr;
  assign acc_sel_o = st_r.acc_sel;
  assign acc_high_half_o = st_r.acc_hi;
  assign acc_low_half_o = st_r.acc_lo;
  assign branch_valid_o = st_r.br_valid;
  assign branch_taken_o = st_r.br_taken;
  assign signal_proc_ctrl_reg_o = st_r.ctrl;
endmodule

// ==== design/daau_pkg.sv ====
// constants, field layout and opcodes of the accumulator access unit
// Behaviour
// - half extract shift from source_reg low five bits
// - half extract clamps to Q15 limits
// - word extract shifts, keeps low 32 bits
// - rounding adds one at top discarded bit
// - round-sat overflow gives largest positive Q31
// - field extract takes size+1 bits, right-aligned
// - field leftmost bit index is position field
// - size from immediate or source_reg low bits
// - decrementing forms lower position by size+1
// - acc shift amount signed, immediate or six bits
// - negative shifts right to 32, positive left 31
// - move-incpos: low to high, source to low, pos+32; the 5-bit position field drops the 32, so pos is unchanged
// - move word between gpr and acc half
// - masked write replaces selected control fields
// - masked read copies selected fields, keeps rest
// - branch taken when position at least 32; the 5-bit position never reaches 32, so the branch is never taken
// - four 64-bit accumulators of two halves
// - position bits 20:16, count bits 14:10
package daau_pkg;
  localparam int WORD_W = 32;
  localparam int ACC_W = 64;
  localparam int ACC_N = 4;
  localparam int SEL_W = 2;
  localparam int SH5_W = 5;
  localparam int SH6_W = 6;
  localparam int MASK_W = 6;
  localparam int POS_LSB = 16;
  localparam int POS_MSB = 20;
  localparam int CNT_LSB = 10;
  localparam int CNT_MSB = 14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [6:0] POS_STEP = 7'h20;
  localparam logic [6:0] BRANCH_MIN = 7'h20;
  localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] Q15_MAX = 32'h0000_7FFF;
  localparam logic [31:0] Q15_MIN = 32'hFFFF_8000;
  // field spans per mask bit: 0 pos, 1 count, 2 low, 3 bit 15, 4 top
  localparam logic [31:0] FLD_POS = 32'h001F_0000;
  localparam logic [31:0] FLD_CNT = 32'h0000_7C00;
  localparam logic [31:0] FLD_LOW = 32'h0000_03FF;
  localparam logic [31:0] FLD_B15 = 32'h0000_8000;
  localparam logic [31:0] FLD_TOP = 32'hFFE0_0000;
  typedef enum logic [4:0] {
    OP_NOP, OP_HALF_SAT, OP_WORD, OP_WORD_R, OP_WORD_RS,
    OP_BF_IMM, OP_BF_VAR, OP_BF_IMM_DEC, OP_BF_VAR_DEC,
    OP_SHIFT_IMM, OP_SHIFT_VAR, OP_MOVE_INCPOS,
    OP_MF_HI, OP_MF_LO, OP_MT_HI, OP_MT_LO,
    OP_CTRL_WR, OP_CTRL_RD, OP_BRANCH_POS
  } daau_op_t;
  typedef enum logic [1:0] {XT_HALF, XT_WORD, XT_FIELD} daau_xt_t;
endpackage

// ==== design/daau_xt_if.sv ====
// operands and results passed between the core and the extract unit
`timescale 1ns/1ps
interface daau_xt_if;
  import daau_pkg::*;
  logic [ACC_W-1:0] acc;
  logic [SH5_W-1:0] amount;
  logic [SH5_W-1:0] pos;
  daau_xt_t kind;
  logic round;
  logic sat;
  logic [WORD_W-1:0] result;
  modport core (output acc, amount, pos, kind, round, sat, input result);
  modport unit (input acc, amount, pos, kind, round, sat, output result);
endinterface

// ==== design/daau_extract.sv ====
// combinational extraction of fractional values and bit fields
`timescale 1ns/1ps
module daau_extract (
  daau_xt_if.unit xt
);
  import daau_pkg::*;
  logic [ACC_W-1:0] shifted;
  logic [ACC_W:0] half_in;
  logic [ACC_W+1:0] rnd_sum;
  logic [WORD_W-1:0] rnd_word;
  logic [6:0] lsb_idx;
  logic [ACC_W-1:0] fld_raw;
  logic [WORD_W-1:0] fld_keep;
  logic hi_pos;
  logic hi_neg;

  // logical right shift by the five-bit amount
  assign shifted = xt.acc >> xt.amount;
  // rounding: add one just below the kept lsb, then drop it
  assign half_in = {xt.acc, 1'b0} >> xt.amount;
  assign rnd_sum = {1'b0, half_in} + {{(ACC_W+1){1'b0}}, 1'b1};
  assign rnd_word = rnd_sum[WORD_W:1];
  // q15 range check of the whole shifted value
  assign hi_pos = ~shifted[ACC_W-1] & (shifted[ACC_W-2:15] != '0);
  assign hi_neg = shifted[ACC_W-1] & (shifted[ACC_W-2:15] != '1);
  // field: leftmost bit at pos, amount holds the size, one less than the bit count
  assign lsb_idx = {2'b00, xt.pos} - {2'b00, xt.amount};
  assign fld_raw = lsb_idx[6] ? (xt.acc << (7'h00 - lsb_idx))
                              : (xt.acc >> lsb_idx);
  assign fld_keep = ~(32'hFFFF_FFFE << xt.amount);

  // result select per extract kind
  always_comb begin
    case (xt.kind)
      XT_HALF: begin
        if (hi_pos) begin
          xt.result = Q15_MAX;
        end else if (hi_neg) begin
          xt.result = Q15_MIN;
        end else begin
          xt.result = {{16{shifted[15]}}, shifted[15:0]};
        end
      end
      XT_WORD: begin
        if (!xt.round) begin
          xt.result = shifted[WORD_W-1:0];
        end else if (xt.sat && !shifted[WORD_W-1] && rnd_word[WORD_W-1]) begin
          xt.result = Q31_MAX;
        end else begin
          xt.result = rnd_word;
        end
      end
      XT_FIELD: begin
        xt.result = fld_raw[WORD_W-1:0] & fld_keep;
      end
      default: begin
        xt.result = '0;
      end
    endcase
  end
endmodule

// ==== test/daau_checker_asserts.sv ====
// checker of the accumulator access unit, bound to its top module
`timescale 1ns/1ps
module daau_checker (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic issue_i,
  input wire daau_pkg::daau_op_t op_i,
  input wire logic [1:0] acc_select_i,
  input wire logic [31:0] source_reg_i,
  input wire logic [31:0] target_reg_i,
  input wire logic [5:0] mask_i,
  input wire logic gpr_wr_o,
  input wire logic [31:0] gpr_data_o,
  input wire logic acc_wr_o,
  input wire logic [1:0] acc_sel_o,
  input wire logic [31:0] acc_high_half_o,
  input wire logic [31:0] acc_low_half_o,
  input wire logic branch_valid_o,
  input wire logic branch_taken_o,
  input wire logic [31:0] signal_proc_ctrl_reg_o
);
  import daau_pkg::*;
  logic tk;
  logic [31:0] cr;
  logic [4:0] ps;
  // taken operation, control register and its position field
  assign tk = rst_b_i && ce_i && issue_i;
  assign cr = signal_proc_ctrl_reg_o;
  assign ps = cr[20:16];
  // control bits covered by a mask
  function automatic logic [31:0] fx(input logic [5:0] k);
    return (k[0] ? FLD_POS : 32'h0) | (k[1] ? FLD_CNT : 32'h0) | (k[2] ? FLD_LOW : 32'h0)
      | (k[3] ? FLD_B15 : 32'h0) | (k[4] ? FLD_TOP : 32'h0);
  endfunction
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_low_read: assert property (
    tk && op_i == OP_MF_LO |=> gpr_wr_o && gpr_data_o == acc_low_half_o
    && acc_sel_o == $past(acc_select_i)) else $error("bad low read");
  a_high_load: assert property (
    tk && op_i == OP_MT_HI |=> acc_wr_o && acc_high_half_o == $past(source_reg_i))
    else $error("bad high load");
  a_incpos_move: assert property (
    tk && op_i == OP_MOVE_INCPOS |=> acc_wr_o && acc_low_half_o == $past(source_reg_i)
    && ps == 5'($past(ps) + 6'h20)) else $error("bad incpos move");
  a_branch_decision: assert property (
    tk && op_i == OP_BRANCH_POS |=> branch_valid_o
    && branch_taken_o == ({2'h0, $past(ps)} >= BRANCH_MIN)) else $error("bad branch");
  a_masked_write: assert property (
    tk && op_i == OP_CTRL_WR |=> cr == (($past(cr) & ~fx($past(mask_i)))
    | ($past(source_reg_i) & fx($past(mask_i))))) else $error("bad masked write");
  a_masked_read: assert property (
    tk && op_i == OP_CTRL_RD |=> gpr_wr_o && gpr_data_o == (($past(target_reg_i)
    & ~fx($past(mask_i))) | ($past(cr) & fx($past(mask_i))))) else $error("bad masked read");
  a_decpos_step: assert property (
    tk && op_i == OP_BF_VAR_DEC |=> gpr_wr_o
    && ps == 5'($past(ps) - $past(source_reg_i[4:0]) - 5'h01)) else $error("bad pos step");
  a_field_keeps_pos: assert property (
    tk && op_i == OP_BF_IMM |=> gpr_wr_o && !acc_wr_o && $stable(cr)) else $error("bad field");
  c_decpos: cover property (tk && op_i == OP_BF_IMM_DEC);
  c_full_write: cover property (tk && op_i == OP_CTRL_WR && mask_i[4:0] == 5'h1F);
  c_branch: cover property (tk && op_i == OP_BRANCH_POS);
endmodule
bind dsp_accumulator_access_unit daau_checker u_chk (.mclk_i, .rst_b_i, .ce_i, .issue_i, .op_i,
  .acc_select_i, .source_reg_i, .target_reg_i, .mask_i, .gpr_wr_o, .gpr_data_o, .acc_wr_o,
  .acc_sel_o, .acc_high_half_o, .acc_low_half_o, .branch_valid_o, .branch_taken_o,
  .signal_proc_ctrl_reg_o);

// ==== test/daau_pipe_model.sv ====
// pipeline model issuing one operation at a time, with random stall cycles
`timescale 1ns/1ps
module daau_pipe_model (
  input wire logic mclk_i,
  output logic ce_o,
  output logic issue_o,
  output daau_pkg::daau_op_t op_o,
  output logic [1:0] sel_o,
  output logic [31:0] src_o,
  output logic [31:0] tgt_o,
  output logic [5:0] imm_o,
  output logic [5:0] mask_o
);
  import daau_pkg::*;
  // idle values at time zero
  initial begin
    {ce_o, issue_o} = 2'h2;
    op_o = OP_NOP;
    {sel_o, src_o, tgt_o, imm_o, mask_o} = '0;
  end
  // present an op; a stall holds it with the enable low, so it is not yet taken
  task automatic send(input daau_op_t op, input logic [1:0] s, input logic [31:0] a,
                      input logic [31:0] b, input logic [5:0] im, input logic [5:0] mk);
    issue_o <= 1'b1;
    op_o <= op;
    {sel_o, src_o, tgt_o, imm_o, mask_o} <= {s, a, b, im, mk};
    if ($urandom_range(3, 0) == 0) begin
      ce_o <= 1'b0;
      @(posedge mclk_i);
    end
    ce_o <= 1'b1;
    @(posedge mclk_i);
  endtask
  // drop the issue line after a burst
  task automatic idle();
    issue_o <= 1'b0;
    @(posedge mclk_i);
  endtask
endmodule

// ==== test/dsp_accumulator_access_unit_tb.sv ====
// self-checking bench for the accumulator access unit
`timescale 1ns/1ps
module dsp_accumulator_access_unit_tb;
  import daau_pkg::*;
  typedef struct packed {
    logic gw, aw, bv, bt;
    logic [31:0] gpr, hi, lo, ctrl;
  } daau_exp_t;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i, issue_i, done_o, gpr_wr_o, acc_wr_o, branch_valid_o, branch_taken_o, taken_d;
  daau_op_t op_i;
  logic [1:0] acc_select_i, acc_sel_o;
  logic [31:0] source_reg_i, target_reg_i, gpr_data_o, acc_high_half_o, acc_low_half_o, ctrl_o;
  logic [5:0] imm_i, mask_i;
  logic [63:0] acc [4];
  logic [31:0] ctrl;
  daau_exp_t exp_q[$];
  daau_exp_t ex;
  int fail_count = 0;
  int checked = 0;
  logic [63:0] av [6] = '{64'h7FFF, 64'h8000, 64'hFFFF_FFFF_FFFF_8000, 64'hFFFF_FFFF_FFFF_7FFF,
                          64'hFFFF_FFFF, 64'h7FFF_FFFF_8000_0000};
  int shv [5] = '{-32, -1, 0, 1, 31};
  int sh3 [3] = '{0, 1, 31};
  daau_op_t xop [4] = '{OP_HALF_SAT, OP_WORD, OP_WORD_R, OP_WORD_RS};
  always #12.5 mclk_i = ~mclk_i;
  daau_pipe_model pipe (.mclk_i, .ce_o(ce_i), .issue_o(issue_i), .op_o(op_i), .sel_o(acc_select_i),
    .src_o(source_reg_i), .tgt_o(target_reg_i), .imm_o(imm_i), .mask_o(mask_i));
  dsp_accumulator_access_unit dut (.mclk_i, .rst_b_i, .ce_i, .issue_i, .op_i, .acc_select_i,
    .source_reg_i, .target_reg_i, .imm_i, .mask_i, .done_o, .gpr_wr_o, .gpr_data_o, .acc_wr_o,
    .acc_sel_o, .acc_high_half_o, .acc_low_half_o, .branch_valid_o, .branch_taken_o,
    .signal_proc_ctrl_reg_o(ctrl_o));
  // comparisons, counted
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic want);
    cmp_word({31'h0, got}, {31'h0, want});
  endtask
  function automatic logic [31:0] fx(input logic [5:0] k);
    return (k[0] ? FLD_POS : 32'h0) | (k[1] ? FLD_CNT : 32'h0) | (k[2] ? FLD_LOW : 32'h0)
      | (k[3] ? FLD_B15 : 32'h0) | (k[4] ? FLD_TOP : 32'h0);
  endfunction
  // reference model: update state, queue expected outputs, then issue
  task automatic run(input daau_op_t op, input logic [1:0] s, input logic [31:0] src,
                     input logic [31:0] tgt, input logic [5:0] im, input logic [5:0] mk);
    logic [63:0] a, v;
    logic [64:0] w;
    logic [31:0] m, r;
    logic [4:0] p, z;
    int k;
    daau_exp_t e;
    a = acc[s];
    p = ctrl[20:16];
    z = (op == OP_BF_IMM || op == OP_BF_IMM_DEC) ? im[4:0] : src[4:0];
    v = a >> src[4:0];
    w = (({1'b0, a} << 1) >> src[4:0]) + 65'h1;
    m = fx(mk);
    k = (op == OP_SHIFT_IMM) ? $signed(im) : $signed(src[5:0]);
    r = 32'h0;
    case (op)
      OP_HALF_SAT: r = ($signed(v) > 64'sh7FFF) ? Q15_MAX : ($signed(v) < -64'sh8000) ? Q15_MIN
          : {{16{v[15]}}, v[15:0]};
      OP_WORD: r = v[31:0];
      OP_WORD_R: r = w[32:1];
      OP_WORD_RS: r = (!v[31] && w[32]) ? Q31_MAX : w[32:1];
      OP_BF_IMM, OP_BF_VAR, OP_BF_IMM_DEC, OP_BF_VAR_DEC: begin
        v = a & ((64'h2 << p) - 64'h1);
        r = (p >= z) ? 32'(v >> (p - z)) : 32'(v << (z - p));
        if (op == OP_BF_IMM_DEC || op == OP_BF_VAR_DEC) ctrl[20:16] = p - z - 5'h01;
      end
      OP_SHIFT_IMM, OP_SHIFT_VAR: a = (k < 0) ? a >> (-k) : a << k;
      OP_MOVE_INCPOS: begin
        a = {a[31:0], src};
        ctrl[20:16] = 5'(p + 6'h20);
      end
      OP_MF_HI: r = a[63:32];
      OP_MF_LO: r = a[31:0];
      OP_MT_HI: a[63:32] = src;
      OP_MT_LO: a[31:0] = src;
      OP_CTRL_WR: ctrl = (ctrl & ~m) | (src & m);
      OP_CTRL_RD: r = (tgt & ~m) | (ctrl & m);
      default: ;
    endcase
    e.gw = op inside {OP_HALF_SAT, OP_WORD, OP_WORD_R, OP_WORD_RS, OP_BF_IMM, OP_BF_VAR,
                      OP_BF_IMM_DEC, OP_BF_VAR_DEC, OP_MF_HI, OP_MF_LO, OP_CTRL_RD};
    e.aw = op inside {OP_SHIFT_IMM, OP_SHIFT_VAR, OP_MOVE_INCPOS, OP_MT_HI, OP_MT_LO};
    e.bv = op == OP_BRANCH_POS;
    e.bt = {2'h0, p} >= BRANCH_MIN;
    {e.gpr, e.hi, e.lo, e.ctrl} = {r, a, ctrl};
    acc[s] = a;
    exp_q.push_back(e);
    pipe.send(op, s, src, tgt, im, mk);
  endtask
  // result check half a cycle after each taken op
  always @(posedge mclk_i) taken_d <= rst_b_i && ce_i && issue_i;
  always @(negedge mclk_i) begin
    if (taken_d === 1'b1) begin
      ex = exp_q.pop_front();
      cmp_bit(done_o, 1'b1);
      cmp_bit(gpr_wr_o, ex.gw);
      if (ex.gw) cmp_word(gpr_data_o, ex.gpr);
      cmp_bit(acc_wr_o, ex.aw);
      cmp_word(acc_high_half_o, ex.hi);
      cmp_word(acc_low_half_o, ex.lo);
      cmp_bit(branch_valid_o, ex.bv);
      if (ex.bv) cmp_bit(branch_taken_o, ex.bt);
      cmp_word(ctrl_o, ex.ctrl);
    end
  end
  // reset for n cycles, then all state and outputs are zero
  task automatic reset(input int n);
    pipe.idle();
    rst_b_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1;
    acc = '{default: 64'h0};
    ctrl = 32'h0;
    cmp_word(ctrl_o | acc_high_half_o | acc_low_half_o, 32'h0);
    cmp_bit(done_o, 1'b0);
    @(posedge mclk_i);
  endtask
  task automatic end_sim();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence: directed boundaries, masks, field chain, random ops with a second reset after op 300
  initial begin
    void'($urandom(81));
    reset(12);
    foreach (av[i]) begin
      run(OP_MT_HI, 2'h1, av[i][63:32], 32'h0, 6'h00, 6'h00);
      run(OP_MT_LO, 2'h1, av[i][31:0], 32'h0, 6'h00, 6'h00);
      foreach (xop[j]) foreach (sh3[q]) run(xop[j], 2'h1, 32'hFFFF_FFE0 | 32'(sh3[q]), 32'h0,
                                            6'h00, 6'h00);
    end
    foreach (shv[i]) begin
      run(OP_MT_HI, 2'h2, $urandom(), 32'h0, 6'h00, 6'h00);
      run(OP_SHIFT_IMM, 2'h2, 32'h0, 32'h0, 6'(shv[i]), 6'h00);
      run(OP_SHIFT_VAR, 2'h2, 32'hFFFF_FFC0 | 32'(6'(shv[i])), 32'h0, 6'h00, 6'h00);
    end
    for (int i = 0; i < 6; i++) begin
      run(OP_CTRL_WR, 2'h0, 32'h0, 32'h0, 6'h00, 6'h3F);
      run(OP_CTRL_WR, 2'h0, 32'hFFFF_FFFF, 32'h0, 6'h00, 6'(1 << i));
      run(OP_CTRL_RD, 2'h0, 32'h0, 32'hA5A5_A5A5, 6'h00, 6'h3F);
    end
    run(OP_CTRL_WR, 2'h3, 32'h001F_0000, 32'h0, 6'h00, 6'h1F);
    run(OP_MT_LO, 2'h3, $urandom(), 32'h0, 6'h00, 6'h00);
    repeat (6) run(OP_BF_IMM_DEC, 2'h3, 32'h0, 32'h0, 6'h07, 6'h00);
    run(OP_BF_VAR, 2'h3, 32'h1F, 32'h0, 6'h00, 6'h00);
    for (int n = 0; n < 500; n++) begin
      if (n == 300) reset(2);
      run(daau_op_t'(5'($urandom_range(18, 0))), 2'($urandom()), $urandom(), $urandom(),
          6'($urandom()), 6'($urandom()));
    end
    pipe.idle();
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge mclk_i);
    if (exp_q.size() > 0) fail_count++;
    end_sim();
  end
endmodule
